// *** crc_status_pkg.sv ***
// Package for the result checksum and status logic of a dual converter.
// Assumes one 25 MHz clock domain and a 16-bit parallel command word.
package crc_status_pkg;

  // ---------------------------------------------------------------
  // Command word layout
  // ---------------------------------------------------------------
  localparam int unsigned CMD_WRITE_BIT = 15;          // Write flag
  localparam int unsigned CMD_ADDR_HI   = 14;          // Address top
  localparam int unsigned CMD_ADDR_LO   = 9;           // Address bottom
  localparam int unsigned CMD_DATA_HI   = 8;           // Data top

  // ---------------------------------------------------------------
  // Register addresses (six-bit address field)
  // ---------------------------------------------------------------
  localparam logic [5:0] ADDR_RESULTS   = 6'h00;       // Conversion codes
  localparam logic [5:0] ADDR_CONFIG    = 6'h02;       // device_config
  localparam logic [5:0] ADDR_CHANNEL   = 6'h03;       // channel_select
  localparam logic [5:0] ADDR_RANGE_AL  = 6'h04;       // range_a_low
  localparam logic [5:0] ADDR_RANGE_AH  = 6'h05;       // range_a_high
  localparam logic [5:0] ADDR_RANGE_BL  = 6'h06;       // range_b_low
  localparam logic [5:0] ADDR_RANGE_BH  = 6'h07;       // range_b_high
  localparam logic [5:0] ADDR_STATUS    = 6'h08;       // Status register
  localparam logic [5:0] ADDR_STACK     = 6'h20;       // Stack base

  // ---------------------------------------------------------------
  // Reset values and fields
  // ---------------------------------------------------------------
  localparam logic [8:0]  CONFIG_RESET  = 9'h000;
  localparam logic [8:0]  CHANNEL_RESET = 9'h000;
  localparam logic [8:0]  RANGE_RESET   = 9'h0ff;
  localparam int unsigned STACK_DEPTH   = 32;
  localparam int unsigned STACK_PRESET  = 8;           // Layers preset
  localparam int unsigned CFG_CRC_BIT   = 0;           // checksum_enable
  localparam int unsigned CFG_STAT_BIT  = 1;           // status_word_enable
  localparam int unsigned CFG_SELF_BIT  = 7;           // self_detect_error_flag

  // Channel identifiers in a four-bit channel field
  localparam logic [3:0] CH_SUPPLY      = 4'h8;        // Supply voltage
  localparam logic [3:0] CH_REGULATOR   = 4'h9;        // internal_regulator_voltage
  localparam logic [3:0] CH_SELF_TEST   = 4'hb;        // Interface self test

  // Self-test fixed codes and checksum seed
  localparam logic [15:0] SELF_CODE_A   = 16'haaaa;
  localparam logic [15:0] SELF_CODE_B   = 16'h5555;
  localparam logic [7:0]  CRC_SEED      = 8'h00;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  a_chan;                               // A-side identity
    logic [3:0]  b_chan;                               // B-side identity
    logic [15:0] a_code;                               // A-side result
    logic [15:0] b_code;                               // B-side result
  } pair_result_t;

  typedef struct packed {
    logic        write;                                // 1 writes, 0 reads
    logic [5:0]  addr;                                 // register_address_field
    logic [8:0]  data;                                 // Payload
  } host_cmd_t;

  typedef enum logic [1:0] {
    RD_IDLE,
    RD_RESULT_A,
    RD_RESULT_B,
    RD_STATUS
  } read_state_t;

endpackage

// *** pair_fifo.sv ***
// Small valid/ready FIFO for converted result pairs.
// Assumes a single clock and an asynchronous active-high reset.
`timescale 1ns/10ps
module pair_fifo #(
  parameter int unsigned WIDTH = 40,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];                       // Storage
  logic [AW-1:0]    wr_q;                              // Write pointer
  logic [AW-1:0]    rd_q;                              // Read pointer
  logic [AW:0]      cnt_q;                             // Fill level
  logic             push;
  logic             pop;

  // Honest full and empty from the fill level
  assign in_ready  = (cnt_q < (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_q];

  // ---------------------------------------------------------------
  // Pointers and level
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Data array has no reset; out_data shows mem[rd_q] even while the FIFO is empty
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
endmodule

// *** result_crc_status_diag.sv ***
// Readout-integrity logic: register set, self-test codes, pair checksum
// and appended status word for a dual simultaneous-sampling converter.
// Assumes the converter core delivers one result pair per strobe and the
// host drives single-cycle read and write strobes on the parallel bus.
//
// Summary of operation
// RULE_01: Channel register selects diagnostic source to convert.
// RULE_02: Self-test channel forces codes AAAA and 5555.
// RULE_03: Checksum only works in software mode.
// RULE_04: Either enable bit turns on checksum and status.
// RULE_05: Status word: channel identity high, checksum low.
// RULE_06: Extra read after results returns status word.
// RULE_07: Checksum starts from zero each sequence; a pop in the sequence_start cycle loads crc_new instead.
// RULE_08: Update with A, then B, for every pair.
// RULE_09: Checksum bit 0 equation.
// RULE_10: Checksum bit 1 equation.
// RULE_11: Checksum bit 2 equation.
// RULE_12: Checksum bit 3 equation.
// RULE_13: Checksum bit 4 equation.
// RULE_14: Checksum bit 5 equation.
// RULE_15: Checksum bit 6 equation.
// RULE_16: Checksum bit 7 equation.
// RULE_17: Host recomputes checksum to detect errors.
// RULE_18: Six config, 32 stack, one status register.
// RULE_19: Reset presets eight stack layers, clears rest.
// RULE_20: A identity top nibble, B identity next.
// RULE_21: Command word: flag, six-bit address, nine data.
// RULE_22: Address 01000 status; 00000 read gives results.
`timescale 1ns/10ps
module result_crc_status_diag #(
  parameter int unsigned FIFO_DEPTH = 8
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        partial_reset,
  input  wire logic        software_mode,
  input  wire logic        self_detect_error,
  input  wire logic        cmd_strobe,
  input  wire logic [15:0] cmd_word,
  input  wire logic        read_strobe,
  output logic [15:0]      read_data,
  input  wire logic        pair_valid,
  output logic             pair_ready,
  input  wire logic [3:0]  pair_a_chan,
  input  wire logic [3:0]  pair_b_chan,
  input  wire logic [15:0] pair_a_code,
  input  wire logic [15:0] pair_b_code,
  input  wire logic        sequence_start,
  output logic [3:0]       conv_a_chan,
  output logic [3:0]       conv_b_chan,
  output logic             checksum_active
);

  // ---------------------------------------------------------------
  // Checksum step over one 16-bit word
  // ---------------------------------------------------------------
  function automatic logic [7:0] crc_step(input logic [15:0] d,
                                          input logic [7:0]  c);
    logic [7:0] o;
    o[0] = d[14]^d[12]^d[8]^d[7]^d[6]^d[0]^c[0]^c[4]^c[6]; // RULE_09
    o[1] = d[15]^d[14]^d[13]^d[12]^d[9]^d[6]^d[1]^d[0]
         ^ c[1]^c[4]^c[5]^c[6]^c[7];                       // RULE_10
    o[2] = d[15]^d[13]^d[12]^d[10]^d[8]^d[6]^d[2]^d[1]^d[0]
         ^ c[0]^c[2]^c[4]^c[5]^c[7];                       // RULE_11
    o[3] = d[14]^d[13]^d[11]^d[9]^d[7]^d[3]^d[2]^d[1]
         ^ c[1]^c[3]^c[5]^c[6];                            // RULE_12
    o[4] = d[15]^d[14]^d[12]^d[10]^d[8]^d[4]^d[3]^d[2]
         ^ c[0]^c[2]^c[4]^c[6]^c[7];                       // RULE_13
    o[5] = d[15]^d[13]^d[11]^d[9]^d[5]^d[4]^d[3]
         ^ c[1]^c[3]^c[5]^c[7];                            // RULE_14
    o[6] = d[14]^d[12]^d[10]^d[6]^d[5]^d[4]^c[2]^c[4]^c[6]; // RULE_15
    o[7] = d[15]^d[13]^d[11]^d[7]^d[6]^d[5]^c[3]^c[5]^c[7]; // RULE_16
    return o;
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [8:0] config_q;                                // device_config
  logic [8:0] channel_q;                               // channel_select
  logic [8:0] range_q [4];                             // Range registers
  logic [8:0] stack_q [crc_status_pkg::STACK_DEPTH];   // Step table
  logic [15:0] status_q;                               // Pair identity, crc
  logic [7:0]  crc_q;                                  // Running checksum
  logic [5:0]  rd_addr_q;                              // Pending read addr
  logic [15:0] read_data_q;                            // Output holding
  crc_status_pkg::read_state_t rd_state_q;             // Readout stage
  crc_status_pkg::host_cmd_t   cmd;                    // Decoded command
  crc_status_pkg::pair_result_t in_pair;               // Pair into FIFO
  crc_status_pkg::pair_result_t head;                  // Pair at FIFO head
  logic        head_valid;
  logic        head_pop;
  logic        crc_on;
  logic [7:0]  crc_mid;
  logic [7:0]  crc_new;

  assign cmd = cmd_word;                               // RULE_21
  // Either enable bit, and software mode only
  assign crc_on = software_mode &&
    (config_q[crc_status_pkg::CFG_CRC_BIT] ||
     config_q[crc_status_pkg::CFG_STAT_BIT]);          // RULE_03 RULE_04
  assign checksum_active = crc_on;
  // Channel identifiers steer the core's input selection
  assign conv_a_chan = channel_q[3:0];                 // RULE_01
  assign conv_b_chan = channel_q[7:4];                 // RULE_01

  // ---------------------------------------------------------------
  // Self-test substitution ahead of the FIFO
  // ---------------------------------------------------------------
  always_comb begin
    in_pair.a_chan = pair_a_chan;
    in_pair.b_chan = pair_b_chan;
    in_pair.a_code = pair_a_code;
    in_pair.b_code = pair_b_code;
    if (pair_a_chan == crc_status_pkg::CH_SELF_TEST) begin
      in_pair.a_code = crc_status_pkg::SELF_CODE_A;    // RULE_02
      in_pair.b_code = crc_status_pkg::SELF_CODE_B;    // RULE_02
    end
  end

  // Results queue; the core stalls when the host falls behind
  pair_fifo #(
    .WIDTH ($bits(crc_status_pkg::pair_result_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_data   (in_pair),
    .in_valid  (pair_valid),
    .in_ready  (pair_ready),
    .out_data  (head),
    .out_valid (head_valid),
    .out_ready (head_pop)
  );

  // ---------------------------------------------------------------
  // Readout sequence: A, B, then status when enabled
  // ---------------------------------------------------------------
  logic rd_results;
  assign rd_results = read_strobe &&
    (rd_addr_q == crc_status_pkg::ADDR_RESULTS);       // RULE_22
  assign head_pop = rd_results && head_valid &&
    (rd_state_q == crc_status_pkg::RD_RESULT_B);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_state_q <= crc_status_pkg::RD_RESULT_A;
    end else if (rd_results) begin
      case (rd_state_q)
        crc_status_pkg::RD_RESULT_A: begin
          if (head_valid) begin
            rd_state_q <= crc_status_pkg::RD_RESULT_B;
          end
        end
        crc_status_pkg::RD_RESULT_B: begin
          // Extra read slot only while checksum is on
          rd_state_q <= crc_on ? crc_status_pkg::RD_STATUS
                               : crc_status_pkg::RD_RESULT_A; // RULE_06
        end
        default: begin
          rd_state_q <= crc_status_pkg::RD_RESULT_A;
        end
      endcase
    end
  end

  // Checksum chained A then B, seeded at zero on sequence_start unless a pop lands in that cycle
  assign crc_mid = crc_step(head.a_code, crc_q);       // RULE_08
  assign crc_new = crc_step(head.b_code, crc_mid);     // RULE_08

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      crc_q    <= crc_status_pkg::CRC_SEED;            // RULE_07
      status_q <= 16'h0000;
    end else if (head_pop) begin
      crc_q    <= crc_new;
      status_q <= {head.a_chan, head.b_chan, crc_new}; // RULE_05 RULE_20
    end else if (sequence_start || partial_reset) begin
      crc_q    <= crc_status_pkg::CRC_SEED;            // RULE_07
    end
  end

  // ---------------------------------------------------------------
  // Register writes and stack presets
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      config_q  <= crc_status_pkg::CONFIG_RESET;
      channel_q <= crc_status_pkg::CHANNEL_RESET;
      rd_addr_q <= crc_status_pkg::ADDR_RESULTS;
      for (int i = 0; i < 4; i++) begin
        range_q[i] <= crc_status_pkg::RANGE_RESET;
      end
    end else begin
      if (cmd_strobe && cmd.write) begin
        if (cmd.addr == crc_status_pkg::ADDR_CONFIG) begin
          config_q <= cmd.data;
        end else if (cmd.addr == crc_status_pkg::ADDR_CHANNEL) begin
          channel_q <= cmd.data;                       // RULE_01
        end else if (cmd.addr >= crc_status_pkg::ADDR_RANGE_AL &&
                     cmd.addr <= crc_status_pkg::ADDR_RANGE_BH) begin
          range_q[cmd.addr[1:0]] <= cmd.data;
        end
      end else if (cmd_strobe) begin
        rd_addr_q <= cmd.addr;                         // RULE_21
      end
    end
  end

  // Stack: reset layer n converts pair n for n below eight
  genvar g;
  generate
    for (g = 0; g < crc_status_pkg::STACK_DEPTH; g++) begin : g_stack
      localparam logic [8:0] PRESET =
        (g < crc_status_pkg::STACK_PRESET) ? 9'(g * 17) : 9'h000;
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          stack_q[g] <= PRESET;                        // RULE_19
        end else if (partial_reset) begin
          stack_q[g] <= PRESET;                        // RULE_19
        end else if (cmd_strobe && cmd.write &&
                     cmd.addr == (crc_status_pkg::ADDR_STACK | 6'(g))) begin
          stack_q[g] <= cmd.data;                      // RULE_18
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read data mux, registered on the read strobe
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      read_data_q <= 16'h0000;
    end else if (read_strobe) begin
      if (rd_addr_q == crc_status_pkg::ADDR_RESULTS) begin
        if (rd_state_q == crc_status_pkg::RD_RESULT_A) begin
          read_data_q <= head.a_code;
        end else if (rd_state_q == crc_status_pkg::RD_RESULT_B) begin
          read_data_q <= head.b_code;
        end else begin
          read_data_q <= status_q;                     // RULE_06
        end
      end else if (rd_addr_q == crc_status_pkg::ADDR_STATUS) begin
        read_data_q <= status_q;                       // RULE_22
      end else if (rd_addr_q == crc_status_pkg::ADDR_CONFIG) begin
        // Error flag is live at bit 7; the stored bit there is unused
        read_data_q <= {1'b0, rd_addr_q, config_q[8],
                        self_detect_error, config_q[6:0]};
      end else if (rd_addr_q == crc_status_pkg::ADDR_CHANNEL) begin
        read_data_q <= {1'b0, rd_addr_q, channel_q};
      end else if (rd_addr_q >= crc_status_pkg::ADDR_RANGE_AL &&
                   rd_addr_q <= crc_status_pkg::ADDR_RANGE_BH) begin
        read_data_q <= {1'b0, rd_addr_q, range_q[rd_addr_q[1:0]]};
      end else if (rd_addr_q[5]) begin
        read_data_q <= {1'b0, rd_addr_q, stack_q[rd_addr_q[4:0]]};
      end else begin
        read_data_q <= 16'h0000;
      end
    end
  end
  assign read_data = read_data_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_SELF_TEST_CODES: assert property (@(posedge clk) disable iff (reset)
    pair_valid && pair_ready && pair_a_chan == crc_status_pkg::CH_SELF_TEST
    |-> in_pair.a_code == 16'haaaa && in_pair.b_code == 16'h5555) // RULE_02
    else $error("self-test codes wrong");
  AST_HW_MODE_NO_CRC: assert property (@(posedge clk) disable iff (reset)
    !software_mode |-> !checksum_active)               // RULE_03
    else $error("checksum active in hardware mode");
  AST_EITHER_ENABLE: assert property (@(posedge clk) disable iff (reset)
    software_mode && (config_q[0] || config_q[1]) |-> checksum_active) // RULE_04
    else $error("enable bit ignored");
  AST_STATUS_LAYOUT: assert property (@(posedge clk) disable iff (reset)
    head_pop |=> status_q[15:12] == $past(head.a_chan) &&
    status_q[11:8] == $past(head.b_chan))              // RULE_05
    else $error("status identity wrong");
  AST_STATUS_AFTER_B: assert property (@(posedge clk) disable iff (reset)
    rd_results && crc_on && rd_state_q == crc_status_pkg::RD_RESULT_B
    |=> rd_state_q == crc_status_pkg::RD_STATUS)       // RULE_06
    else $error("no status slot after results");
  AST_SEED_ZERO: assert property (@(posedge clk) disable iff (reset)
    sequence_start && !head_pop |=> crc_q == 8'h00)    // RULE_07
    else $error("checksum not reseeded");
  AST_CHAIN: assert property (@(posedge clk) disable iff (reset)
    head_pop |=> crc_q == crc_step($past(head.b_code),
      crc_step($past(head.a_code), $past(crc_q))))     // RULE_08
    else $error("checksum chain wrong");
  AST_STACK_PRESET: assert property (@(posedge clk) disable iff (reset)
    partial_reset |=> stack_q[3] == 9'h033 && stack_q[9] == 9'h000) // RULE_19
    else $error("stack preset wrong");
endmodule

// *** host_model.sv ***
// Host controller model on the parallel command and read bus.
// Assumes the bench calls its tasks; the bus moves on falling edges.
`timescale 1ns/10ps
module host_model (
  input  wire logic        clk,
  input  wire logic [15:0] read_data,
  output logic             cmd_strobe,
  output logic [15:0]      cmd_word,
  output logic             read_strobe
);
  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  // Idle bus at time zero
  initial begin
    cmd_strobe  = 1'b0;
    cmd_word    = 16'h0000;
    read_strobe = 1'b0;
  end

  // One command word: flag, address, nine data bits
  task automatic command(input logic wr, input logic [5:0] addr,
                         input logic [8:0] data);
    @(negedge clk);
    cmd_word   = {wr, addr, data};
    cmd_strobe = 1'b1;
    @(negedge clk);
    cmd_strobe = 1'b0;
    // Released word is inverted so a stale value is never trusted
    cmd_word   = ~cmd_word;
  endtask

  // One read strobe; the word is taken a cycle later
  task automatic read(output logic [15:0] data);
    @(negedge clk);
    read_strobe = 1'b1;
    @(negedge clk);
    read_strobe = 1'b0;
    data        = read_data;
  endtask

  // Host side recomputation of the pair checksum
  function automatic logic [7:0] crc_step(input logic [15:0] d,
                                          input logic [7:0]  c);
    // Checksum taps sit in the top byte of each data mask
    logic [15:0] m [8] = '{16'h51c1,
                           16'hf243,
                           16'hb547,
                           16'h6a8e,
                           16'hd51c,
                           16'haa38,
                           16'h5470,
                           16'ha8e0};
    for (int i = 0; i < 8; i++) begin
      crc_step[i] = ^(d & m[i]) ^ ^(c & m[i][15:8]);
    end
  endfunction
endmodule

// *** testbench.sv ***
// Self-checking bench for the checksum and status logic.
// Assumes host_model drives the bus; the bench feeds converted pairs.
`timescale 1ns/10ps
module testbench;
  logic        clk, reset, partial_reset, software_mode;
  logic        self_detect_error, cmd_strobe, read_strobe;
  logic        pair_valid, pair_ready, sequence_start, checksum_active;
  logic [15:0] cmd_word, read_data, pair_a_code, pair_b_code, rd;
  logic [3:0]  pair_a_chan, pair_b_chan, conv_a_chan, conv_b_chan;
  logic [7:0]  crc;
  int          err_count, comparisons;

  result_crc_status_diag dut_u (.clk(clk), .reset(reset),
    .partial_reset(partial_reset), .software_mode(software_mode),
    .self_detect_error(self_detect_error), .cmd_strobe(cmd_strobe),
    .cmd_word(cmd_word), .read_strobe(read_strobe),
    .read_data(read_data), .pair_valid(pair_valid),
    .pair_ready(pair_ready), .pair_a_chan(pair_a_chan),
    .pair_b_chan(pair_b_chan), .pair_a_code(pair_a_code),
    .pair_b_code(pair_b_code), .sequence_start(sequence_start),
    .conv_a_chan(conv_a_chan), .conv_b_chan(conv_b_chan),
    .checksum_active(checksum_active));
  host_model host_u (.clk(clk), .read_data(read_data),
    .cmd_strobe(cmd_strobe), .cmd_word(cmd_word),
    .read_strobe(read_strobe));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Hand one pair over; bounded wait for room
  task automatic push(input logic [3:0] ac, bc, input logic [15:0] a, b);
    int n;
    n = 0;
    @(negedge clk);
    while (pair_ready !== 1'b1 && n < 20) begin
      n++;
      @(negedge clk);
    end
    if (n == 20) begin
      chk("pair_ready", {15'h0, pair_ready}, 16'h0001);
      final_report();
    end
    {pair_a_chan, pair_b_chan, pair_a_code, pair_b_code} = {ac, bc, a, b};
    pair_valid = 1'b1;
    @(negedge clk);
    pair_valid  = 1'b0;
    pair_a_code = ~a;
    pair_b_code = ~b;
  endtask

  // Reseed the checksum on both sides
  task automatic seq_start;
    @(negedge clk);
    sequence_start = 1'b1;
    @(negedge clk);
    sequence_start = 1'b0;
    crc = 8'h00;
  endtask

  // Reset values, stack preset and partial reset
  task automatic t_reset;
    self_detect_error = 1'b1;
    host_u.command(1'b0, crc_status_pkg::ADDR_CONFIG, 9'h000);
    host_u.read(rd);
    chk("config", {7'h00, rd[8:0]}, 16'h0080);
    for (int r = 3; r < 8; r++) begin
      host_u.command(1'b0, 6'(r), 9'h000);
      host_u.read(rd);
      chk("cfg_reg", {7'h00, rd[8:0]}, r == 3 ? 16'h0000 : 16'h00ff);
    end
    for (int n = 0; n < 32; n++) begin
      host_u.command(1'b0, crc_status_pkg::ADDR_STACK + 6'(n), 9'h000);
      host_u.read(rd);
      chk("stack", {7'h00, rd[8:0]}, n < 8 ? 16'(n * 17) : 16'h0000);
    end
    host_u.command(1'b1, 6'h22, 9'h1ab);
    @(negedge clk);
    partial_reset = 1'b1;
    @(negedge clk);
    partial_reset = 1'b0;
    host_u.command(1'b0, 6'h22, 9'h000);
    host_u.read(rd);
    chk("stack_preset", {7'h00, rd[8:0]}, 16'h0022);
    self_detect_error = 1'b0;
    $display("done t_reset");
  endtask

  // Chained checksum over two pairs, status word after each
  task automatic t_crc(input logic [8:0] cfg);
    logic [15:0] av [2] = '{16'h8001, 16'hffff};
    logic [15:0] bv [2] = '{16'h7ffe, 16'h0000};
    software_mode = 1'b1;
    host_u.command(1'b1, crc_status_pkg::ADDR_CONFIG, cfg);
    chk("active", {15'h0, checksum_active}, 16'h0001);
    seq_start();
    host_u.command(1'b0, crc_status_pkg::ADDR_RESULTS, 9'h000);
    for (int p = 0; p < 2; p++) begin
      push(4'(p + 1), 4'(p + 5), av[p], bv[p]);
      host_u.read(rd);
      chk("code_a", rd, av[p]);
      host_u.read(rd);
      chk("code_b", rd, bv[p]);
      crc = host_u.crc_step(bv[p], host_u.crc_step(av[p], crc));
      host_u.read(rd);
      chk("status", rd, {4'(p + 1), 4'(p + 5), crc});
    end
    $display("done t_crc");
  endtask

  // Channel selection and self-test codes
  task automatic t_self;
    host_u.command(1'b1, crc_status_pkg::ADDR_CHANNEL, 9'h089);
    chk("conv_chan", {8'h00, conv_b_chan, conv_a_chan}, 16'h0089);
    host_u.command(1'b1, crc_status_pkg::ADDR_CHANNEL, 9'h0bb);
    chk("conv_a", {12'h0, conv_a_chan}, 16'h000b);
    seq_start();
    host_u.command(1'b0, crc_status_pkg::ADDR_RESULTS, 9'h000);
    push(4'hb, 4'hb, 16'h1234, 16'h4321);
    host_u.read(rd);
    chk("self_a", rd, 16'haaaa);
    host_u.read(rd);
    chk("self_b", rd, 16'h5555);
    crc = host_u.crc_step(16'h5555, host_u.crc_step(16'haaaa, crc));
    host_u.read(rd);
    chk("self_status", rd, {8'hbb, crc});
    $display("done t_self");
  endtask

  // Hardware mode: no status word; FIFO filled then drained
  task automatic t_fifo;
    software_mode = 1'b0;
    @(negedge clk);
    chk("active_hw", {15'h0, checksum_active}, 16'h0000);
    for (int p = 0; p < 8; p++) push(4'h0, 4'h0, 16'(p), 16'(p + 100));
    chk("full", {15'h0, pair_ready}, 16'h0000);
    for (int p = 0; p < 8; p++) begin
      host_u.read(rd);
      chk("fifo_a", rd, 16'(p));
      host_u.read(rd);
      chk("fifo_b", rd, 16'(p + 100));
    end
    chk("empty", {15'h0, pair_ready}, 16'h0001);
    $display("done t_fifo");
  endtask

  initial begin
    {reset, partial_reset, software_mode, self_detect_error} = 4'b1000;
    {pair_valid, sequence_start, pair_a_chan, pair_b_chan} = 10'h000;
    {pair_a_code, pair_b_code} = 32'h0000_0000;
    err_count   = 0;
    comparisons = 0;
    repeat (16) @(negedge clk);
    reset = 1'b0;
    t_reset();
    t_crc(9'h001);
    t_crc(9'h002);
    t_self();
    t_fifo();
    final_report();
  end
endmodule
